/* File: status_word_cfg.svh */
// Constants for the upper configuration status word: offsets, field positions and codes.
`ifndef STATUS_WORD_CFG_SVH
`define STATUS_WORD_CFG_SVH

`define SW_OFF_LOW          4'h0
`define SW_OFF_HIGH         4'h4
`define SW_OFF_CTRL         4'h8
`define SW_OFF_ID           4'hC

`define SW_CUR_LSB          24
`define SW_EXEC_BIT         28
`define SW_IDERR_BIT        29
`define SW_INVCMD_BIT       30
`define SW_WDT_BIT          31
`define SW_DRYDONE_BIT      33
`define SW_PREV_LSB         34
`define SW_BYPASS_BIT       38
`define SW_FLOW_BIT         39
`define SW_SFDP_BIT         42
`define SW_KEYDES_BIT       43
`define SW_INITN_BIT        44
`define SW_PAR2_BIT         45
`define SW_IBUS_BIT         46
`define SW_PAR1_BIT         47
`define SW_AUTH_LSB         48
`define SW_AUTHDONE_BIT     50
`define SW_DRYAUTH_BIT      51
`define SW_LOCK_LSB         52
`define SW_LOCK_COUNT       12

`define SW_CODE_NONE        4'h0
`define SW_CODE_MAX         4'hA
`define SW_EVT_COUNT        9
`define SW_CTRL_CLEAR_BIT   0
`define SW_STICKY_RESET     9'h000
`define SW_DATA_ZERO        32'h0000_0000
`define SW_RESP_OKAY        2'h0
`define SW_RESP_SLVERR      2'h2
`define SW_ID_VALUE         32'h0000_5A5A

`endif

/* File: status_word_pkg.sv */
// Types shared by the status word block.
package status_word_pkg;

    // Hardware event pulses that set sticky flags.
    typedef struct packed {
        logic par1;
        logic ibus;
        logic par2;
        logic keyDestroy;
        logic sfdpTimeout;
        logic dryRunAuthDone;
        logic authDone;
        logic dryRunDone;
        logic executionError;
    } event_t;

    // Live levels mirrored into the word one cycle later, through registers.
    typedef struct packed {
        logic [11:0] locks;
        logic [1:0]  authMode;
        logic        initnPin;
        logic        flowThrough;
        logic        bypass;
        logic        watchdogBusy;
    } level_t;

    // Engine result reporting.
    typedef struct packed {
        logic       start;
        logic       resultValid;
        logic [3:0] resultCode;
        logic       idCheck;
        logic       idMismatch;
        logic       cmdValid;
        logic       cmdIllegal;
    } engine_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;

endpackage

/* File: status_sticky.sv */
// Sticky event flags: a set in the clearing cycle wins over the clear.
`timescale 1ns/1ns
`include "status_word_cfg.svh"
module status_sticky
(
    input  wire logic                       mclk,     // System clock.
    input  wire logic                       srst,     // Synchronous reset.
    input  wire logic [`SW_EVT_COUNT-1:0]   setPulse, // Event pulses.
    input  wire logic                       clear,    // Software clear.
    output logic      [`SW_EVT_COUNT-1:0]   flags_q   // Sticky flags.
);
    genvar i;
    generate
        for (i = 0; i < `SW_EVT_COUNT; i = i + 1)
        begin : gFlag
            always_ff @(posedge mclk)
            begin
                if (srst)
                    flags_q[i] <= 1'b0;
                else if (setPulse[i])
                    flags_q[i] <= 1'b1;
                else if (clear)
                    flags_q[i] <= 1'b0;
            end
        end
    endgenerate
endmodule

/* File: config_status_upper_word.sv */
// Upper status word (bits 24 to 63) of the configuration engine with an AXI4-Lite slave.
//
// Contract
// - Bits 27:24 hold current engine result code, eleven defined values.
// - Bits 37:34 hold previous execution result code, same encoding.
// - Bit 28 sets on execution error; bit 30 on invalid command.
// - Bit 29 sets when identity verify command value mismatches.
// - Bit 31 reads one while configuration watchdog is busy.
// - Bit 33 sets when dry run sets pseudo completion.
// - Bit 38 reads one while in daisy-chain bypass mode.
// - Bit 39 reads one while in daisy-chain pass-through mode.
// - Bit 42 sets on master flash port signature read timeout.
// - Bit 43 sets when key destroy completes successfully.
// - Bit 45 sets on S2 parity error, bit 47 on S1.
// - Bit 46 sets on initialization bus identifier error.
// - Bits 49:48 report authentication mode; 00 and 11 mean none.
// - Bit 50 sets once bitstream authentication completes.
// - Bit 51 sets once dry run authentication completes.
// - Bits 52, 53, 54 report JTAG, serial, I2C/I3C port locks.
// - Bits 55, 56 report public key read and write locks.
// - Bits 57, 58 report feature row read and write locks.
// - Bits 59, 60 report stored key read and write locks.
// - Bits 61, 62 report password store read and write locks.
// - Bit 63 reports global lock on one-time programmable rows.
`timescale 1ns/1ns
`include "status_word_cfg.svh"
module config_status_upper_word
(
    input  wire logic                   mclk,          // 50 MHz clock.
    input  wire logic                   srst,          // Synchronous reset, high.
    input  wire status_word_pkg::engine_t engine,      // Engine result inputs.
    input  wire status_word_pkg::event_t  events,      // Event pulses.
    input  wire status_word_pkg::level_t  levels,      // Live state levels.
    input  wire logic                   s_axi_awvalid, // Write address valid.
    output logic                        s_axi_awready, // Write address ready.
    input  wire logic [3:0]             s_axi_awaddr,  // Write address.
    input  wire logic [2:0]             s_axi_awprot,  // Write protection.
    input  wire logic                   s_axi_wvalid,  // Write data valid.
    output logic                        s_axi_wready,  // Write data ready.
    input  wire logic [31:0]            s_axi_wdata,   // Write data.
    input  wire logic [3:0]             s_axi_wstrb,   // Write strobes.
    output logic                        s_axi_bvalid,  // Write response valid.
    input  wire logic                   s_axi_bready,  // Write response ready.
    output logic      [1:0]             s_axi_bresp,   // Write response.
    input  wire logic                   s_axi_arvalid, // Read address valid.
    output logic                        s_axi_arready, // Read address ready.
    input  wire logic [3:0]             s_axi_araddr,  // Read address.
    input  wire logic [2:0]             s_axi_arprot,  // Read protection.
    output logic                        s_axi_rvalid,  // Read data valid.
    input  wire logic                   s_axi_rready,  // Read data ready.
    output logic      [31:0]            s_axi_rdata,   // Read data.
    output logic      [1:0]             s_axi_rresp,   // Read response.
    output logic      [63:0]            statusWord     // Full word, bits 23:0 zero.
);

    logic [3:0]                 curCode_q;
    logic [3:0]                 prevCode_q;
    logic                       idErr_q;
    logic                       invCmd_q;
    logic [`SW_EVT_COUNT-1:0]   sticky;
    logic                       swClear;
    logic [63:0]                word;
    status_word_pkg::level_t    levels_q;

    logic                       awHeld_q;
    logic                       wHeld_q;
    logic [3:0]                 awAddr_q;
    logic [31:0]                wData_q;
    logic                       wStrb0_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    status_word_pkg::rd_state_t rdState_q;
    logic [31:0]                rdata_q;
    logic [1:0]                 rresp_q;
    logic                       wrFire;

    // Result code tracking; a new start retires the current code.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            curCode_q  <= `SW_CODE_NONE;
            prevCode_q <= `SW_CODE_NONE;
        end
        else if (engine.start)
        begin
            prevCode_q <= curCode_q;
            curCode_q  <= `SW_CODE_NONE;
        end
        else if (engine.resultValid && engine.resultCode <= `SW_CODE_MAX)
            curCode_q  <= engine.resultCode;
    end

    // Identity and command flags stick until a new execution or software clear.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            idErr_q  <= 1'b0;
            invCmd_q <= 1'b0;
        end
        else
        begin
            if (engine.idCheck && engine.idMismatch)
                idErr_q <= 1'b1;
            else if (swClear || engine.start)
                idErr_q <= 1'b0;
            if (engine.cmdValid && engine.cmdIllegal)
                invCmd_q <= 1'b1;
            else if (swClear || engine.start)
                invCmd_q <= 1'b0;
        end
    end

    // Live levels are registered so the word comes from flip-flops.
    always_ff @(posedge mclk)
    begin
        if (srst)
            levels_q <= '0;
        else
            levels_q <= levels;
    end

    status_sticky u_sticky
    (
        .mclk     (mclk),
        .srst     (srst),
        .setPulse (events),
        .clear    (swClear),
        .flags_q  (sticky)
    );

    // Word assembly; reserved bits 32, 40, 41 and the low bits stay zero.
    always_comb
    begin
        word = '0;
        word[`SW_CUR_LSB +: 4]   = curCode_q;
        word[`SW_EXEC_BIT]       = sticky[0];
        word[`SW_IDERR_BIT]      = idErr_q;
        word[`SW_INVCMD_BIT]     = invCmd_q;
        word[`SW_WDT_BIT]        = levels_q.watchdogBusy;
        word[`SW_DRYDONE_BIT]    = sticky[1];
        word[`SW_PREV_LSB +: 4]  = prevCode_q;
        word[`SW_BYPASS_BIT]     = levels_q.bypass;
        word[`SW_FLOW_BIT]       = levels_q.flowThrough;
        word[`SW_SFDP_BIT]       = sticky[4];
        word[`SW_KEYDES_BIT]     = sticky[5];
        word[`SW_INITN_BIT]      = levels_q.initnPin;
        word[`SW_PAR2_BIT]       = sticky[6];
        word[`SW_IBUS_BIT]       = sticky[7];
        word[`SW_PAR1_BIT]       = sticky[8];
        word[`SW_AUTH_LSB +: 2]  = levels_q.authMode;
        word[`SW_AUTHDONE_BIT]   = sticky[2];
        word[`SW_DRYAUTH_BIT]    = sticky[3];
        // Port, key, row and password locks, then the global lock.
        word[`SW_LOCK_LSB +: `SW_LOCK_COUNT] = levels_q.locks;
    end

    assign statusWord = word;

    // Write channel: address and data taken in either order.
    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready  = !wHeld_q && !bvalid_q;
    assign wrFire = (awHeld_q || s_axi_awvalid) && (wHeld_q || s_axi_wvalid) && !bvalid_q;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q  <= `SW_DATA_ZERO;
            wStrb0_q <= 1'b0;
        end
        else if (wrFire)
        begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q  <= 1'b1;
                wData_q  <= s_axi_wdata;
                wStrb0_q <= s_axi_wstrb[0];
            end
        end
    end

    // Only the control word accepts writes; the status words are read only.
    always_comb
    begin
        logic [3:0]  a;
        logic [31:0] d;
        logic        s;
        a = awHeld_q ? awAddr_q : s_axi_awaddr;
        d = wHeld_q ? wData_q : s_axi_wdata;
        s = wHeld_q ? wStrb0_q : s_axi_wstrb[0];
        swClear = wrFire && (a == `SW_OFF_CTRL) && s && d[`SW_CTRL_CLEAR_BIT];
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `SW_RESP_OKAY;
        end
        else if (wrFire)
        begin
            bvalid_q <= 1'b1;
            if ((awHeld_q ? awAddr_q : s_axi_awaddr) == `SW_OFF_CTRL)
                bresp_q <= `SW_RESP_OKAY;
            else
                bresp_q <= `SW_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Read channel: one cycle from address to data.
    assign s_axi_arready = (rdState_q == status_word_pkg::RD_IDLE);

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rdState_q <= status_word_pkg::RD_IDLE;
            rdata_q   <= `SW_DATA_ZERO;
            rresp_q   <= `SW_RESP_OKAY;
        end
        else
        begin
            case (rdState_q)
                status_word_pkg::RD_IDLE:
                begin
                    if (s_axi_arvalid)
                    begin
                        rdState_q <= status_word_pkg::RD_RESP;
                        rresp_q   <= `SW_RESP_OKAY;
                        case (s_axi_araddr)
                            `SW_OFF_LOW:  rdata_q <= word[31:0];
                            `SW_OFF_HIGH: rdata_q <= word[63:32];
                            `SW_OFF_CTRL: rdata_q <= `SW_DATA_ZERO;
                            `SW_OFF_ID:   rdata_q <= `SW_ID_VALUE;
                            default:
                            begin
                                rdata_q <= `SW_DATA_ZERO;
                                rresp_q <= `SW_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                status_word_pkg::RD_RESP:
                begin
                    if (s_axi_rready)
                        rdState_q <= status_word_pkg::RD_IDLE;
                end
                default:
                    rdState_q <= status_word_pkg::RD_IDLE;
            endcase
        end
    end

    assign s_axi_rvalid = (rdState_q == status_word_pkg::RD_RESP);
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule

/* File: config_status_upper_word_props.sv */
// Assertions on the upper status word block.
`timescale 1ns/1ns
`include "status_word_cfg.svh"
module config_status_upper_word_props
(
    input wire logic                     mclk,         // Clock.
    input wire logic                     srst,         // Reset.
    input wire status_word_pkg::engine_t engine,       // Engine inputs.
    input wire status_word_pkg::event_t  events,       // Event pulses.
    input wire status_word_pkg::level_t  levels,       // Live levels.
    input wire logic                     s_axi_bvalid, // Write response valid.
    input wire logic [1:0]               s_axi_bresp,  // Write response.
    input wire logic [63:0]              statusWord    // Status word.
);
    // Sticky flags gathered in the bit order of the event pulses.
    logic [8:0] flags;
    assign flags = {statusWord[47:45], statusWord[43:42], statusWord[51:50], statusWord[33],
                    statusWord[28]};
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    sequence s_good_code;
        engine.resultValid && !engine.start && (engine.resultCode <= `SW_CODE_MAX);
    endsequence
    sequence s_bad_code;
        engine.resultValid && !engine.start && (engine.resultCode > `SW_CODE_MAX);
    endsequence
    property p_reserved;
        statusWord[41:40] == 2'h0 && !statusWord[32] && statusWord[23:0] == 24'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_code_load;
        s_good_code |=> statusWord[27:24] == $past(engine.resultCode);
    endproperty
    a_code_load: assert property (p_code_load) else $error("code not loaded");
    property p_code_ignore;
        s_bad_code |=> $stable(statusWord[27:24]);
    endproperty
    a_code_ignore: assert property (p_code_ignore) else $error("bad code taken");
    property p_prev_copy;
        engine.start && !engine.resultValid |=>
            statusWord[37:34] == $past(statusWord[27:24]) && statusWord[27:24] == `SW_CODE_NONE;
    endproperty
    a_prev_copy: assert property (p_prev_copy) else $error("no copy");
    property p_id_set;
        engine.idCheck && engine.idMismatch && !engine.start |=> statusWord[29];
    endproperty
    a_id_set: assert property (p_id_set) else $error("id flag not set");
    property p_cmd_set;
        engine.cmdValid && engine.cmdIllegal && !engine.start |=> statusWord[30];
    endproperty
    a_cmd_set: assert property (p_cmd_set) else $error("command flag not set");
    property p_event_set;
        1'h1 |=> (flags & $past(events)) == $past(events);
    endproperty
    a_event_set: assert property (p_event_set) else $error("event lost");
    property p_flag_hold;
        !$past(srst) && (~flags & $past(flags)) != 9'h0 |->
            $rose(s_axi_bvalid) && s_axi_bresp == `SW_RESP_OKAY;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
    property p_levels;
        !$past(srst) |-> statusWord[63:52] == $past(levels.locks)
            && statusWord[49:48] == $past(levels.authMode)
            && statusWord[39] == $past(levels.flowThrough)
            && statusWord[38] == $past(levels.bypass)
            && statusWord[31] == $past(levels.watchdogBusy);
    endproperty
    a_levels: assert property (p_levels) else $error("level not mirrored");
endmodule

/* File: config_status_upper_word_tb.sv */
// Self-checking bench for the upper status word block.
`timescale 1ns/1ns
`include "status_word_cfg.svh"
module config_status_upper_word_tb;
    logic                     mclk = 1'h0;
    logic                     srst = 1'h1;
    status_word_pkg::engine_t engine = '0;
    status_word_pkg::event_t  events = '0;
    status_word_pkg::level_t  levels = '0;
    status_word_pkg::level_t  lv = '0;
    logic                     awValid = 1'h0, wValid = 1'h0, arValid = 1'h0;
    logic                     bReady = 1'h0, rReady = 1'h0;
    logic [3:0]               awAddr = 4'h0, arAddr = 4'h0;
    logic [31:0]              wData = 32'h0;
    logic                     awReady, wReady, bValid, arReady, rValid;
    logic [1:0]               bResp, rResp;
    logic [31:0]              rData;
    logic [63:0]              word;
    logic [8:0]               fl = 9'h0;
    logic [3:0]               cur = 4'h0, prv = 4'h0;
    logic                     idE = 1'h0, invE = 1'h0;
    int                       failures = 0, n_tests = 0, cycles = 0;

    config_status_upper_word DUT (.mclk(mclk), .srst(srst), .engine(engine), .events(events),
        .levels(levels), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .statusWord(word));

    always #10 mclk = ~mclk;

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures = failures + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (failures == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t response %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [63:0] model();
        return {lv.locks, fl[3:2], lv.authMode, fl[8:6], lv.initnPin, fl[5:4], 2'h0,
                lv.flowThrough, lv.bypass, prv, fl[1], 1'h0, lv.watchdogBusy, invE, idE,
                fl[0], cur, 24'h0};
    endfunction

    // Ready and answer are sampled at the falling edge, where they are settled.
    task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic        tkA, done;
        logic [31:0] got;
        logic [1:0]  gr;
        @(posedge mclk);
        arAddr <= a;
        arValid <= 1'h1;
        rReady <= 1'h1;
        do
        begin
            @(negedge mclk);
            tkA = arValid && arReady === 1'h1;
            done = rValid === 1'h1;
            got = rData;
            gr = rResp;
            @(posedge mclk);
            if (tkA)
                arValid <= 1'h0;
        end
        while (!done);
        rReady <= 1'h0;
        chk_data(got, ed);
        chk_resp(gr, er);
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       tkA, tkW, done;
        logic [1:0] gr;
        @(posedge mclk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'h1;
        wValid <= 1'h1;
        bReady <= 1'h1;
        do
        begin
            @(negedge mclk);
            tkA = awValid && awReady === 1'h1;
            tkW = wValid && wReady === 1'h1;
            done = bValid === 1'h1;
            gr = bResp;
            @(posedge mclk);
            if (tkA)
                awValid <= 1'h0;
            if (tkW)
                wValid <= 1'h0;
        end
        while (!done);
        bReady <= 1'h0;
        chk_resp(gr, er);
    endtask

    task automatic check_word();
        logic [63:0] m;
        m = model();
        axi_read(`SW_OFF_LOW, m[31:0], `SW_RESP_OKAY);
        axi_read(`SW_OFF_HIGH, m[63:32], `SW_RESP_OKAY);
        @(negedge mclk);
        chk_data(word[31:0], m[31:0]);
        chk_data(word[63:32], m[63:32]);
    endtask

    task automatic pulse(input logic [8:0] e, input logic [9:0] g);
        @(posedge mclk);
        events <= e;
        engine <= g;
        @(posedge mclk);
        events <= '0;
        engine <= '0;
    endtask

    initial
    begin
        repeat (4) @(posedge mclk);
        srst <= 1'h0;
        check_word();
        axi_read(`SW_OFF_ID, `SW_ID_VALUE, `SW_RESP_OKAY);
        axi_read(`SW_OFF_CTRL, `SW_DATA_ZERO, `SW_RESP_OKAY);
        axi_read(4'h2, `SW_DATA_ZERO, `SW_RESP_SLVERR);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            lv = {12'hA5C ^ {12{i[0]}}, i[1:0], i[0], i[1], ~i[0], i[0]};
            levels <= lv;
            check_word();
        end
        for (int i = 0; i < 9; i++)
        begin
            pulse(9'h1 << i, 10'h000);
            fl[i] = 1'h1;
            check_word();
        end
        axi_write(`SW_OFF_CTRL, 32'h0000_0000, `SW_RESP_OKAY);
        axi_write(`SW_OFF_HIGH, 32'hFFFF_FFFF, `SW_RESP_SLVERR);
        axi_write(`SW_OFF_LOW, 32'hFFFF_FFFF, `SW_RESP_SLVERR);
        pulse(9'h000, 10'h00A);
        check_word();
        pulse(9'h000, 10'h00F);
        idE = 1'h1;
        invE = 1'h1;
        check_word();
        axi_write(`SW_OFF_CTRL, 32'h0000_0001, `SW_RESP_OKAY);
        fl = 9'h0;
        idE = 1'h0;
        invE = 1'h0;
        check_word();
        pulse(9'h000, 10'h00F);
        idE = 1'h1;
        invE = 1'h1;
        for (int c = 0; c < 12; c++)
        begin
            pulse(9'h000, {2'h1, c[3:0], 4'h0});
            if (c <= 10)
                cur = c[3:0];
            check_word();
            pulse(9'h000, 10'h200);
            prv = cur;
            cur = 4'h0;
            idE = 1'h0;
            invE = 1'h0;
            check_word();
        end
        pulse(9'h1FF, {2'h1, 4'h7, 4'hF});
        fl = 9'h1FF;
        cur = 4'h7;
        idE = 1'h1;
        invE = 1'h1;
        check_word();
        @(posedge mclk);
        srst <= 1'h1;
        @(posedge mclk);
        @(negedge mclk);
        chk_data(word[63:32], `SW_DATA_ZERO);
        chk_data(word[31:0], `SW_DATA_ZERO);
        @(posedge mclk);
        srst <= 1'h0;
        fl = 9'h0;
        cur = 4'h0;
        idE = 1'h0;
        invE = 1'h0;
        check_word();
        final_report();
    end
endmodule

bind config_status_upper_word config_status_upper_word_props u_props (.mclk(mclk), .srst(srst),
    .engine(engine), .events(events), .levels(levels), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bresp(s_axi_bresp), .statusWord(statusWord));
